// ---- servo_opt_pkg.sv ----
// constants and types shared by the servo option register bank
package servo_opt_pkg;

    // -------------------------------------------------------------
    // register indices and byte addresses (byte address = 4 x index)
    // -------------------------------------------------------------
    localparam logic [9:0] IDX_FUNC_SEL_A = 10'h024;
    localparam logic [9:0] IDX_IO_POL_MASK = 10'h025;
    localparam logic [9:0] IDX_IN_ALLOC_A = 10'h026;
    localparam logic [9:0] IDX_FUNC_SEL_B = 10'h027;
    localparam logic [11:0] ADDR_FUNC_SEL_A = {IDX_FUNC_SEL_A, 2'b00};
    localparam logic [11:0] ADDR_IO_POL_MASK = {IDX_IO_POL_MASK, 2'b00};
    localparam logic [11:0] ADDR_IN_ALLOC_A = {IDX_IN_ALLOC_A, 2'b00};
    localparam logic [11:0] ADDR_FUNC_SEL_B = {IDX_FUNC_SEL_B, 2'b00};

    // -------------------------------------------------------------
    // reset values and implemented-bit masks (unused bits read zero)
    // -------------------------------------------------------------
    localparam logic [15:0] RST_OPTION = 16'h0000;
    localparam logic [15:0] MASK_FUNC_SEL_A = 16'h7FFF;
    localparam logic [15:0] MASK_IO_POL_MASK = 16'hFFDF;
    localparam logic [15:0] MASK_IN_ALLOC_A = 16'hFFFF;
    localparam logic [15:0] MASK_FUNC_SEL_B = 16'h1FFF;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int FA_START_CUR = 14;
    localparam int FA_MODE_LSB = 12;
    localparam int FA_ECHO = 11;
    localparam int FA_OK_REPLY = 10;
    localparam int FA_ERR_REPLY = 9;
    localparam int FA_IGN_NO_AXIS = 8;
    localparam int FA_ENC_LSB = 4;
    localparam int FA_PULSE_TRAIN = 3;
    localparam int FA_ABS_ENC = 2;
    localparam int FA_ALT_ORIGIN = 1;
    localparam int FA_ORIGIN_NEG = 0;
    localparam int IO_INV_LSB = 12;
    localparam int IO_MASK_LSB = 8;
    localparam int IO_SPECIAL = 6;
    localparam int IO_INV_DECEL = 4;
    localparam int IO_MASK_ALARM_RST = 3;
    localparam int IO_EXT_JOG = 2;
    localparam int IO_MASK_OVERTRAVEL = 1;
    localparam int IO_MASK_SERVO_ON = 0;
    localparam int FB_IGN_PARITY = 12;
    localparam int FB_PDC_MULT = 11;
    localparam int FB_PDC_EN = 10;
    localparam int FB_REF_BUF = 9;
    localparam int FB_OVERWRITE = 8;
    localparam int FB_MARKER_EXT = 7;
    localparam int FB_ORG_METH_LSB = 4;

    // -------------------------------------------------------------
    // field limits
    // -------------------------------------------------------------
    localparam logic [3:0] ENC_CHECK_MAX = 4'h5;
    localparam logic [3:0] ALLOC_CODE_MAX = 4'h8;
    localparam logic [2:0] ORIGIN_METHOD_MAX = 3'h6;

    // allocatable input pins, also their nibble order in the allocation words
    localparam int PIN_SERVO_ON = 0;
    localparam int PIN_PROP_CTRL = 1;
    localparam int PIN_FWD = 2;
    localparam int PIN_REV = 3;
    localparam int PIN_ALARM_RST = 4;
    localparam int NUM_ALLOC = 5;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic alarmReset;
        logic originReturn;
        logic skip;
        logic registration;
        logic hold;
        logic start;
        logic propControl;
        logic servoOn;
    } cmd_t;

    typedef struct packed {
        logic startFromCurrent;
        logic [1:0] modeSwitchSel;
        logic [3:0] encPulseCheck;
        logic pulseTrainRef;
        logic absEncoder;
        logic altOriginMethod;
        logic originDirNeg;
        logic extJogEn;
        logic ignoreParity;
        logic pdcWidthMult;
        logic refBuffer;
        logic overwrite;
        logic originMarkerExt;
        logic [2:0] originMethod;
    } cfg_t;

endpackage : servo_opt_pkg

// ---- input_allocator.sv ----
// maps allocatable input pins onto sequence commands by allocation code
`timescale 1ns/100ps
module input_allocator
    import servo_opt_pkg::*;
(
    // pin levels and their codes
    input wire logic [NUM_ALLOC-1:0] pinLevel,
    input wire logic [4*NUM_ALLOC-1:0] codes,
    // resulting commands, combinational
    output cmd_t cmdAlloc
);

    // code 0 means none, codes 1..8 select one command bit
    function automatic logic [7:0] decode_code(input logic [3:0] code, input logic level);
        logic [7:0] hot;
        hot = 8'h00;
        if (code != 4'h0 && code <= ALLOC_CODE_MAX)
            hot[3'(code - 4'h1)] = level;
        decode_code = hot;
    endfunction : decode_code

    logic [7:0] hotPer [NUM_ALLOC];
    logic [7:0] orAcc [NUM_ALLOC+1];

    // several pins on one command are or-ed together
    assign orAcc[0] = 8'h00;
    genvar g;
    generate
        for (g = 0; g < NUM_ALLOC; g++)
        begin : g_pin
            assign hotPer[g] = decode_code(codes[4*g +: 4], pinLevel[g]);
            assign orAcc[g+1] = orAcc[g] | hotPer[g];
        end
    endgenerate
    assign cmdAlloc = cmd_t'(orAcc[NUM_ALLOC]);

endmodule : input_allocator

// ---- serial_reply_gate.sv ----
// gates serial message acceptance and reply requests by option bits
`timescale 1ns/100ps
module serial_reply_gate
    import servo_opt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // option bits
    input wire logic echoEn,
    input wire logic okReplyEn,
    input wire logic errReplyEn,
    input wire logic ignoreNoAxis,
    // requests from the serial link logic
    input wire logic msgValid,
    input wire logic msgHasAxis,
    input wire logic echoReq,
    input wire logic okReq,
    input wire logic errReq,
    // registered results
    output logic msgAccept,
    output logic echoSend,
    output logic okSend,
    output logic errSend
);

    logic acceptNext;

    // messages without an axis number are dropped only when asked
    assign acceptNext = msgValid & (msgHasAxis | ~ignoreNoAxis);

    // one register stage keeps the top outputs glitch free
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            msgAccept <= 1'b0;
            echoSend <= 1'b0;
            okSend <= 1'b0;
            errSend <= 1'b0;
        end
        else
        begin
            msgAccept <= acceptNext;
            echoSend <= echoReq & echoEn;
            okSend <= okReq & okReplyEn;
            errSend <= errReq & errReplyEn;
        end
    end

    chk_reply_gate: assert property (@(posedge clk) disable iff (srst)
        (echoSend | okSend | errSend) |->
        $past((echoReq & echoEn) | (okReq & okReplyEn) | (errReq & errReplyEn)))
        else $error("reply sent without its enable");
    chk_no_axis_drop: assert property (@(posedge clk) disable iff (srst)
        (msgValid && !msgHasAxis && ignoreNoAxis) |=> !msgAccept)
        else $error("message without axis number accepted");

endmodule : serial_reply_gate

// ---- servo_io_option_config.sv ----
// option word register bank with output polarity and input allocation
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module servo_io_option_config
    import servo_opt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // input terminals, asynchronous
    input wire logic servoOnIn,
    input wire logic propControlIn,
    input wire logic forwardLimitIn,
    input wire logic reverseLimitIn,
    input wire logic alarmResetIn,
    input wire logic originDecelIn,
    input wire logic overtravelIn,
    // raw status from the servo core, same clock
    input wire logic currentLimitRaw,
    input wire logic positionDoneRaw,
    input wire logic brakeRaw,
    input wire logic alarmRaw,
    input wire logic pulseDistDoneRaw,
    // serial link requests, same clock
    input wire logic msgValid,
    input wire logic msgHasAxis,
    input wire logic echoReq,
    input wire logic okReq,
    input wire logic errReq,
    // output terminals
    output logic currentLimitOut,
    output logic positionDoneOut,
    output logic brakeOut,
    output logic alarmOut,
    output logic pulseDistDoneOut,
    // conditioned inputs and commands to the sequence logic
    output logic originDecel,
    output logic overtravel,
    output cmd_t cmdOut,
    output cfg_t cfgOut,
    // serial gating results
    output logic msgAccept,
    output logic echoSend,
    output logic okSend,
    output logic errSend
);

    // -------------------------------------------------------------
    // option word storage
    // -------------------------------------------------------------
    logic [15:0] funcSelA_reg;
    logic [15:0] ioPolMask_reg;
    logic [15:0] inAllocA_reg;
    logic [15:0] funcSelB_reg;
    logic [31:0] prdata_next;
    logic pslverr_next;

    // address decode
    wire hitA = (paddr == ADDR_FUNC_SEL_A);
    wire hitIo = (paddr == ADDR_IO_POL_MASK);
    wire hitAlloc = (paddr == ADDR_IN_ALLOC_A);
    wire hitB = (paddr == ADDR_FUNC_SEL_B);
    wire hitAny = hitA | hitIo | hitAlloc | hitB;
    wire setupPhase = psel & ~penable;
    wire writeDone = psel & penable & pready & pwrite;

    // byte-lane merge onto the addressed word, then clear unused bits
    wire [15:0] curWord = hitA ? funcSelA_reg : hitIo ? ioPolMask_reg :
                          hitAlloc ? inAllocA_reg : funcSelB_reg;
    wire [15:0] curMask = hitA ? MASK_FUNC_SEL_A : hitIo ? MASK_IO_POL_MASK :
                          hitAlloc ? MASK_IN_ALLOC_A : MASK_FUNC_SEL_B;
    wire [15:0] mergedWord = {pstrb[1] ? pwdata[15:8] : curWord[15:8],
                              pstrb[0] ? pwdata[7:0] : curWord[7:0]};
    wire [15:0] wrWord = mergedWord & curMask;

    // range checks: an out-of-range field refuses the whole write
    wire badA = hitA & (wrWord[FA_ENC_LSB +: 4] > ENC_CHECK_MAX);
    wire badIo = hitIo & wrWord[IO_SPECIAL + 1];
    wire badAlloc = hitAlloc & ((wrWord[15:12] > ALLOC_CODE_MAX) |
                    (wrWord[11:8] > ALLOC_CODE_MAX) |
                    (wrWord[7:4] > ALLOC_CODE_MAX) |
                    (wrWord[3:0] > ALLOC_CODE_MAX));
    wire badB = hitB & ((wrWord[FB_ORG_METH_LSB +: 3] > ORIGIN_METHOD_MAX) |
                (wrWord[3:0] > ALLOC_CODE_MAX));
    wire wrBad = pwrite & (badA | badIo | badAlloc | badB);
    wire wrOk = writeDone & ~pslverr;

    // read data and error are prepared in the setup cycle
    always_comb
    begin
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (!hitAny)
            pslverr_next = 1'b1;
        else
        begin
            pslverr_next = wrBad;
            if (!pwrite)
                prdata_next = {16'h0000, curWord};
        end
    end

    // zero-wait apb: ready rises for exactly the access cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setupPhase;
            if (setupPhase)
            begin
                prdata <= prdata_next;
                pslverr <= pslverr_next;
            end
            else if (pready)
            begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // words are stored as the masked merge, with unused bits held at zero
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            funcSelA_reg <= RST_OPTION;
            ioPolMask_reg <= RST_OPTION;
            inAllocA_reg <= RST_OPTION;
            funcSelB_reg <= RST_OPTION;
        end
        else if (wrOk)
        begin
            if (hitA)
                funcSelA_reg <= wrWord;
            if (hitIo)
                ioPolMask_reg <= wrWord;
            if (hitAlloc)
                inAllocA_reg <= wrWord;
            if (hitB)
                funcSelB_reg <= wrWord;
        end
    end

    // -------------------------------------------------------------
    // configuration fields to the servo core
    // -------------------------------------------------------------
    assign cfgOut.modeSwitchSel = funcSelA_reg[FA_MODE_LSB +: 2];
    assign cfgOut.startFromCurrent = funcSelA_reg[FA_START_CUR];
    assign cfgOut.encPulseCheck = funcSelA_reg[FA_ENC_LSB +: 4];
    assign cfgOut.pulseTrainRef = funcSelA_reg[FA_PULSE_TRAIN];
    assign cfgOut.absEncoder = funcSelA_reg[FA_ABS_ENC];
    assign cfgOut.altOriginMethod = funcSelA_reg[FA_ALT_ORIGIN];
    assign cfgOut.originDirNeg = funcSelA_reg[FA_ORIGIN_NEG];
    assign cfgOut.extJogEn = ioPolMask_reg[IO_EXT_JOG];
    assign cfgOut.ignoreParity = funcSelB_reg[FB_IGN_PARITY];
    assign cfgOut.pdcWidthMult = funcSelB_reg[FB_PDC_MULT];
    assign cfgOut.refBuffer = funcSelB_reg[FB_REF_BUF];
    assign cfgOut.overwrite = funcSelB_reg[FB_OVERWRITE];
    assign cfgOut.originMarkerExt = funcSelB_reg[FB_MARKER_EXT];
    assign cfgOut.originMethod = funcSelB_reg[FB_ORG_METH_LSB +: 3];

    // -------------------------------------------------------------
    // input terminal synchronisers
    // -------------------------------------------------------------
    logic [6:0] pinMeta_reg;
    logic [6:0] pinSync_reg;
    wire [6:0] pinRaw = {overtravelIn, originDecelIn, alarmResetIn, reverseLimitIn,
                         forwardLimitIn, propControlIn, servoOnIn};

    // two stages; only the second is read anywhere
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pinMeta_reg <= 7'h00;
            pinSync_reg <= 7'h00;
        end
        else
        begin
            pinMeta_reg <= pinRaw;
            pinSync_reg <= pinMeta_reg;
        end
    end

    // -------------------------------------------------------------
    // command generation
    // -------------------------------------------------------------
    cmd_t cmdAlloc;
    cmd_t cmdGeneral;
    cmd_t cmd_next;
    wire specialMode = ioPolMask_reg[IO_SPECIAL];
    wire [4*NUM_ALLOC-1:0] allocCodes = {funcSelB_reg[3:0], inAllocA_reg};
    wire [NUM_ALLOC-1:0] allocLevels = pinSync_reg[NUM_ALLOC-1:0];

    input_allocator u_alloc
    (
        .pinLevel(allocLevels),
        .codes(allocCodes),
        .cmdAlloc(cmdAlloc)
    );

    // general mode: fixed terminals, servo-on and alarm-reset each subject to its mask bit
    always_comb
    begin
        cmdGeneral = '0;
        cmdGeneral.servoOn = pinSync_reg[PIN_SERVO_ON] & ~ioPolMask_reg[IO_MASK_SERVO_ON];
        cmdGeneral.propControl = pinSync_reg[PIN_PROP_CTRL];
        cmdGeneral.alarmReset = pinSync_reg[PIN_ALARM_RST]
                                & ~ioPolMask_reg[IO_MASK_ALARM_RST];
    end

    // allocation only applies when the special-input bit is set
    assign cmd_next = specialMode ? cmdAlloc : cmdGeneral;

    // -------------------------------------------------------------
    // output terminals: status mask forces inactive, then optional inversion; pulse-distribution done only gated by its enable bit
    // -------------------------------------------------------------
    wire [3:0] statRaw = {currentLimitRaw, positionDoneRaw, brakeRaw, alarmRaw};
    wire [3:0] statInv = ioPolMask_reg[IO_INV_LSB +: 4];
    wire [3:0] statMask = ioPolMask_reg[IO_MASK_LSB +: 4];
    wire [3:0] stat_next = (statRaw & ~statMask) ^ statInv;

    // one register stage for every terminal so outputs never glitch
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            {currentLimitOut, positionDoneOut, brakeOut, alarmOut} <= 4'h0;
            pulseDistDoneOut <= 1'b0;
            originDecel <= 1'b0;
            overtravel <= 1'b0;
            cmdOut <= '0;
        end
        else
        begin
            {currentLimitOut, positionDoneOut, brakeOut, alarmOut} <= stat_next;
            pulseDistDoneOut <= pulseDistDoneRaw & funcSelB_reg[FB_PDC_EN];
            originDecel <= pinSync_reg[5] ^ ioPolMask_reg[IO_INV_DECEL];
            overtravel <= pinSync_reg[6] & ~ioPolMask_reg[IO_MASK_OVERTRAVEL];
            cmdOut <= cmd_next;
        end
    end

    // -------------------------------------------------------------
    // serial link gating
    // -------------------------------------------------------------
    serial_reply_gate u_reply
    (
        .clk(clk),
        .srst(srst),
        .echoEn(funcSelA_reg[FA_ECHO]),
        .okReplyEn(funcSelA_reg[FA_OK_REPLY]),
        .errReplyEn(funcSelA_reg[FA_ERR_REPLY]),
        .ignoreNoAxis(funcSelA_reg[FA_IGN_NO_AXIS]),
        .msgValid(msgValid),
        .msgHasAxis(msgHasAxis),
        .echoReq(echoReq),
        .okReq(okReq),
        .errReq(errReq),
        .msgAccept(msgAccept),
        .echoSend(echoSend),
        .okSend(okSend),
        .errSend(errSend)
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    chk_reset_zero: assert property (@(posedge clk)
        $past(srst) |-> (funcSelA_reg | ioPolMask_reg | inAllocA_reg | funcSelB_reg) == 16'h0000)
        else $error("option word not zero after reset");
    chk_unused_zero: assert property (@(posedge clk) disable iff (srst)
        !funcSelA_reg[15] && !ioPolMask_reg[5] && funcSelB_reg[15:13] == 3'h0)
        else $error("unused option bit set");
    chk_mode_write: assert property (@(posedge clk) disable iff (srst)
        (wrOk && hitA && pstrb[1]) |=> cfgOut.modeSwitchSel == $past(pwdata[13:12]))
        else $error("mode switch field not written");
    chk_enc_range: assert property (@(posedge clk) disable iff (srst)
        cfgOut.encPulseCheck <= ENC_CHECK_MAX)
        else $error("encoder check field out of range");
    chk_alloc_range: assert property (@(posedge clk) disable iff (srst)
        (psel && penable && pready && pwrite && hitAlloc && pstrb[0]
         && pwdata[3:0] > ALLOC_CODE_MAX) |-> pslverr ##1 $stable(inAllocA_reg))
        else $error("out-of-range allocation code accepted");
    chk_origin_range: assert property (@(posedge clk) disable iff (srst)
        cfgOut.originMethod <= ORIGIN_METHOD_MAX)
        else $error("origin method out of range");
    chk_alarm_invert: assert property (@(posedge clk) disable iff (srst)
        $past(!srst) |-> alarmOut == $past((alarmRaw & ~ioPolMask_reg[8]) ^ ioPolMask_reg[12]))
        else $error("alarm output polarity wrong");
    chk_decel_path: assert property (@(posedge clk) disable iff (srst)
        ($past(!srst, 3) && $past(!srst, 2) && $past(!srst)) |->
        originDecel == ($past(originDecelIn, 3) ^ $past(ioPolMask_reg[4])))
        else $error("origin decel inversion wrong");
    chk_alarm_rst_mask: assert property (@(posedge clk) disable iff (srst)
        $past(ioPolMask_reg[IO_MASK_ALARM_RST] && !specialMode) |-> !cmdOut.alarmReset)
        else $error("masked alarm reset passed");
    chk_pdc_gate: assert property (@(posedge clk) disable iff (srst)
        pulseDistDoneOut |-> $past(funcSelB_reg[FB_PDC_EN] && pulseDistDoneRaw))
        else $error("pulse distribution output while disabled");
    chk_apb_ready: assert property (@(posedge clk) disable iff (srst)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("ready not a single access cycle");

    cov_write_a: cover property (@(posedge clk) wrOk && hitA);
    cov_unmapped: cover property (@(posedge clk) pready && pslverr && !hitAny);
    cov_special: cover property (@(posedge clk) specialMode && cmdOut.start);
    cov_rst_masked: cover property (@(posedge clk)
        !specialMode && ioPolMask_reg[IO_MASK_ALARM_RST] && pinSync_reg[PIN_ALARM_RST]);

endmodule : servo_io_option_config

// ---- pin_source_model.sv ----
// behavioural sequence controller that drives the input terminals
`timescale 1ns/100ps
module pin_source_model
(
    // clock
    input wire logic clk,
    // requested levels
    input wire logic [6:0] pinReq,
    // terminal levels
    output logic [6:0] pinOut
);
    // levels move just after an edge, never mid-cycle
    always_ff @(posedge clk)
    begin
        pinOut <= pinReq;
    end
endmodule : pin_source_model

// ---- servo_io_option_config_tb.sv ----
// self-checking bench for the servo option register bank
`timescale 1ns/100ps
module servo_io_option_config_tb
    import servo_opt_pkg::*;
;
    // ---------------------------------------------
    // signals
    // ---------------------------------------------
    logic clk, srst, psel, penable, pwrite, pready, pslverr, er, originDecel;
    logic overtravel, pulseDistDoneOut;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic currentLimitRaw, positionDoneRaw, brakeRaw, alarmRaw, pulseDistDoneRaw;
    logic msgValid, msgHasAxis, echoReq, okReq, errReq;
    logic currentLimitOut, positionDoneOut, brakeOut, alarmOut;
    logic msgAccept, echoSend, okSend, errSend;
    logic [6:0] pinReq, pinOut;
    logic [11:0] regs [4];
    cmd_t cmdOut;
    cfg_t cfgOut;
    int bad_count, cmp_count;

    pin_source_model pin_source_model_i (.clk, .pinReq, .pinOut);
    servo_io_option_config servo_io_option_config_i (
        .clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .servoOnIn(pinOut[0]),
        .propControlIn(pinOut[1]), .forwardLimitIn(pinOut[2]), .reverseLimitIn(pinOut[3]),
        .alarmResetIn(pinOut[4]), .originDecelIn(pinOut[5]), .overtravelIn(pinOut[6]),
        .currentLimitRaw, .positionDoneRaw, .brakeRaw, .alarmRaw, .pulseDistDoneRaw,
        .msgValid, .msgHasAxis, .echoReq, .okReq, .errReq, .currentLimitOut,
        .positionDoneOut, .brakeOut, .alarmOut, .pulseDistDoneOut, .originDecel,
        .overtravel, .cmdOut, .cfgOut, .msgAccept, .echoSend, .okSend, .errSend);

    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            bad_count++;
            $display("ERROR at %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    // one apb transfer; pready, prdata and pslverr are taken at the edge ending it
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20)
        begin
            bad_count++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ---------------------------------------------
    // clock and sequence
    // ---------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        {srst, pstrb} = 5'h13;
        {psel, penable, pwrite, paddr, pwdata, pinReq} = '0;
        {currentLimitRaw, positionDoneRaw, brakeRaw, alarmRaw, pulseDistDoneRaw} = '0;
        {msgValid, msgHasAxis, echoReq, okReq, errReq} = '0;
        regs = '{ADDR_FUNC_SEL_A, ADDR_IO_POL_MASK, ADDR_IN_ALLOC_A, ADDR_FUNC_SEL_B};
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            apb(regs[i], 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        apb(ADDR_FUNC_SEL_A, 1'b1, 32'h0000FF5F);
        apb(ADDR_FUNC_SEL_A, 1'b0, 32'h0);
        chk(rd, 32'h00007F5F);
        chk(cfgOut.modeSwitchSel, 32'h3);
        chk(cfgOut.encPulseCheck, 32'h5);
        apb(ADDR_FUNC_SEL_A, 1'b1, 32'h00007F6F);
        chk(er, 32'h1);
        apb(ADDR_FUNC_SEL_A, 1'b0, 32'h0);
        chk(rd, 32'h00007F5F);
        // all replies asked for a message that lacks an axis number
        {msgValid, echoReq, okReq, errReq} <= 4'hF;
        @(posedge clk);
        {msgValid, echoReq, okReq, errReq} <= 4'h0;
        #1;
        chk({msgAccept, echoSend, okSend, errSend}, 32'h7);
        apb(12'h0A0, 1'b0, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        apb(ADDR_IO_POL_MASK, 1'b1, 32'h0000F000);
        repeat (2) @(posedge clk);
        #1;
        chk({currentLimitOut, positionDoneOut, brakeOut, alarmOut}, 32'hF);
        // alarm masked to inactive before its inversion, current limit raw high
        apb(ADDR_IO_POL_MASK, 1'b1, 32'h0000F100);
        {currentLimitRaw, alarmRaw} <= 2'h3;
        repeat (2) @(posedge clk);
        #1;
        chk({currentLimitOut, positionDoneOut, brakeOut, alarmOut}, 32'h7);
        apb(ADDR_IN_ALLOC_A, 1'b1, 32'h00008888);
        apb(ADDR_IN_ALLOC_A, 1'b0, 32'h0);
        chk(rd, 32'h00008888);
        // allocated mode, servo-on, alarm-reset and overtravel pins high
        apb(ADDR_IO_POL_MASK, 1'b1, 32'h00000050);
        pinReq <= 7'h51;
        for (int c = 1; c <= 8; c++)
        begin
            apb(ADDR_IN_ALLOC_A, 1'b1, 32'(c));
            repeat (4) @(posedge clk);
            #1;
            chk(cmdOut, 32'h1 << (c - 1));
        end
        chk(originDecel, 32'h1);
        chk(overtravel, 32'h1);
        apb(ADDR_IN_ALLOC_A, 1'b1, 32'h9);
        chk(er, 32'h1);
        // general mode with alarm-reset and overtravel masked
        apb(ADDR_IO_POL_MASK, 1'b1, 32'h0000000A);
        pulseDistDoneRaw <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(cmdOut, 32'h1);
        chk(overtravel, 32'h0);
        apb(ADDR_FUNC_SEL_B, 1'b1, 32'h00000070);
        chk(er, 32'h1);
        #1;
        chk(pulseDistDoneOut, 32'h0);
        apb(ADDR_FUNC_SEL_B, 1'b1, 32'h00000400);
        repeat (2) @(posedge clk);
        #1;
        chk(pulseDistDoneOut, 32'h1);
        results();
    end
endmodule : servo_io_option_config_tb
